// [core/ptp_consts.svh]
`ifndef PTP_CONSTS_SVH
`define PTP_CONSTS_SVH
`define PTP_CTRL_INDEX     16'h60B8
`define PTP_CTRL_RESET     16'h0000
`define PTP_B1_ENABLE      0
`define PTP_B1_CONT        1
`define PTP_B1_SEL         2
`define PTP_B1_RISE        4
`define PTP_B1_FALL        5
`define PTP_B2_ENABLE      8
`define PTP_B2_CONT        9
`define PTP_B2_SEL         10
`define PTP_B2_RISE        12
`define PTP_B2_FALL        13
`endif

// [core/ptp_pkg.sv]
package ptp_pkg;
  typedef struct packed {
    logic enable;
    logic cont;
    logic sel;
    logic rise;
    logic fall;
  } ptp_chan_s;
endpackage

// [core/ptp_probe_ctrl.sv]
`timescale 1ns/1ns
`include "ptp_consts.svh"
// Contract
// [R01] The control word is 16-bit read-write, reset to zero, any value.
// [R02] Bit 0 enables probe one; cleared, probe one latches nothing.
// [R03] Bit 1 cleared makes probe one capture once, on its first edge.
// [R04] A set trigger-action bit makes a probe capture on every enabled edge.
// [R05] Bit 2 cleared takes probe one's trigger from the external pin.
// [R06] A set trigger-selection bit takes the origin or timing output.
// [R07] Bit 4 set lets a rising edge of probe one's trigger capture.
// [R08] Bit 5 set lets a falling edge of probe one's trigger capture.
// [R09] A cleared edge-action bit makes that edge never capture.
// [R10] Bits 3, 6 and 7 are reserved, written zero, without effect.
// [R11] Bit 8 enables probe two; cleared, probe two latches nothing.
// [R12] Bit 9 picks single-shot or continuous capture for probe two.
// [R13] Bit 10 picks probe two's source: external clear, internal set.
// [R14] Bits 12 and 13 are probe two's rising and falling edge enables.
// [R15] An edge stores the position; single-shot re-arms on enable toggle.
module ptp_probe_ctrl #(
  parameter int POS_W = 32
) (
  input  wire logic             clk_i,      // System clock
  input  wire logic             reset_n_i,  // Async reset, low
  input  wire logic             wr_en_i,    // Control word write strobe
  input  wire logic [15:0]      wr_data_i,  // Control word write data
  output logic      [15:0]      ctrl_o,     // Control word readback
  input  wire logic [1:0]       external_latch_input_one_i, // Pins per probe
  input  wire logic [1:0]       excitation_origin_output_i, // Internal
  input  wire logic [1:0]       timing_pulse_output_i,      // Internal
  input  wire logic [POS_W-1:0] position_i, // Current position
  output logic [1:0]            captured_o, // One-cycle capture pulse
  output logic [POS_W-1:0]      cap_pos1_o, // Probe one capture
  output logic [POS_W-1:0]      cap_pos2_o  // Probe two capture
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0]        ctrl_q;
  logic [15:0]        ctrl_d;
  logic [1:0]         ext_m_q;
  logic [1:0]         ext_s_q;
  logic [1:0]         trig_q;
  logic [1:0]         trig_d;
  logic [1:0]         done_q;
  logic [1:0]         done_d;
  logic [1:0]         cap_q;
  logic [1:0]         cap_d;
  logic [1:0]         hit;
  logic [POS_W-1:0]   p1_q;
  logic [POS_W-1:0]   p1_d;
  logic [POS_W-1:0]   p2_q;
  logic [POS_W-1:0]   p2_d;
  ptp_pkg::ptp_chan_s ch [2];

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Both probes share one field layout, offset by their enable bit
  function automatic ptp_pkg::ptp_chan_s unpack(input logic [15:0] w,
                                                input int          b);
    unpack.enable = w[b];
    unpack.cont   = w[b+`PTP_B1_CONT-`PTP_B1_ENABLE];
    unpack.sel    = w[b+`PTP_B1_SEL-`PTP_B1_ENABLE];
    unpack.rise   = w[b+`PTP_B1_RISE-`PTP_B1_ENABLE];
    unpack.fall   = w[b+`PTP_B1_FALL-`PTP_B1_ENABLE];
  endfunction

  // A cleared edge bit masks that edge completely
  function automatic logic edge_hit(input ptp_pkg::ptp_chan_s c,
                                    input logic               now,
                                    input logic               was);
    edge_hit = (c.rise & now & ~was) |  // see [R07]
               (c.fall & ~now & was);   // see [R08] [R09]
  endfunction

  // ****************************************************************
  // Control word
  // ****************************************************************
  // Reserved bits are stored and read back but feed no logic
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_en_i) begin
      ctrl_d = wr_data_i; // see [R01]
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `PTP_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_comb begin
    ch[0] = unpack(ctrl_q, `PTP_B1_ENABLE); // see [R10]
    ch[1] = unpack(ctrl_q, `PTP_B2_ENABLE); // see [R14]
  end

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // Only the second stage is read; the first may be metastable
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_m_q <= 2'h0;
      ext_s_q <= 2'h0;
    end else begin
      ext_m_q <= external_latch_input_one_i;
      ext_s_q <= ext_m_q;
    end
  end

  // ****************************************************************
  // Trigger select and edge detect
  // ****************************************************************
  // Internal sources are same-clock logic, so they skip the sync
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (ch[i].sel) begin
        trig_d[i] = excitation_origin_output_i[i] |
                    timing_pulse_output_i[i]; // see [R06] [R13]
      end else begin
        trig_d[i] = ext_s_q[i]; // see [R05]
      end
      hit[i] = edge_hit(ch[i], trig_d[i], trig_q[i]);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_q <= 2'h0;
    end else begin
      trig_q <= trig_d;
    end
  end

  // ****************************************************************
  // Capture and single-shot arming
  // ****************************************************************
  // A capture wins over a write clearing enable in the same cycle
  always_comb begin
    done_d = done_q;
    cap_d  = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (!ch[i].enable) begin
        done_d[i] = 1'b0; // see [R02] [R11] [R15]
      end else if (hit[i] && (ch[i].cont || !done_q[i])) begin // see [R04]
        cap_d[i]  = 1'b1;
        done_d[i] = ~ch[i].cont; // see [R03] [R12]
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_q <= 2'h0;
      cap_q  <= 2'h0;
    end else begin
      done_q <= done_d;
      cap_q  <= cap_d;
    end
  end

  // ****************************************************************
  // Position capture
  // ****************************************************************
  always_comb begin
    p1_d = p1_q;
    p2_d = p2_q;
    if (cap_d[0]) begin
      p1_d = position_i; // see [R15]
    end
    if (cap_d[1]) begin
      p2_d = position_i; // see [R15]
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p1_q <= '0;
      p2_q <= '0;
    end else begin
      p1_q <= p1_d;
      p2_q <= p2_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ctrl_o     = ctrl_q;
  assign captured_o = cap_q;
  assign cap_pos1_o = p1_q;
  assign cap_pos2_o = p2_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ctrl_write: assert property ( // see [R01]
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_en_i |=> ctrl_o == $past(wr_data_i))
    else $error("control word not written");

  a_disabled_quiet: assert property ( // see [R02]
    @(posedge clk_i) disable iff (!reset_n_i)
    !ctrl_q[`PTP_B1_ENABLE] |=> !captured_o[0])
    else $error("disabled probe one captured");

  a_two_quiet: assert property ( // see [R11]
    @(posedge clk_i) disable iff (!reset_n_i)
    !ctrl_q[`PTP_B2_ENABLE] |=> !captured_o[1])
    else $error("disabled probe two captured");

  a_single_once: assert property ( // see [R03]
    @(posedge clk_i) disable iff (!reset_n_i)
    captured_o[0] && !ctrl_q[`PTP_B1_CONT] && $stable(ctrl_q)
    |-> !cap_d[0])
    else $error("single shot captured twice");

  a_single_two: assert property ( // see [R12]
    @(posedge clk_i) disable iff (!reset_n_i)
    captured_o[1] && !ctrl_q[`PTP_B2_CONT] && $stable(ctrl_q)
    |-> !cap_d[1])
    else $error("probe two single shot captured twice");

  a_cont_again: assert property ( // see [R04]
    @(posedge clk_i) disable iff (!reset_n_i)
    ctrl_q[`PTP_B1_ENABLE] && ctrl_q[`PTP_B1_CONT] && hit[0]
    |=> captured_o[0])
    else $error("continuous probe missed an edge");

  a_pos_store: assert property ( // see [R15]
    @(posedge clk_i) disable iff (!reset_n_i)
    cap_d[1] |=> cap_pos2_o == $past(position_i))
    else $error("position not stored");

  a_pos1_store: assert property ( // see [R15]
    @(posedge clk_i) disable iff (!reset_n_i)
    cap_d[0] |=> cap_pos1_o == $past(position_i))
    else $error("probe one position not stored");

  a_no_edge: assert property ( // see [R09]
    @(posedge clk_i) disable iff (!reset_n_i)
    !ctrl_q[`PTP_B1_RISE] && !ctrl_q[`PTP_B1_FALL] |-> !cap_d[0])
    else $error("capture with no edge enabled");
endmodule

// [testbench/ptp_far_end.sv]
`timescale 1ns/1ns
module ptp_far_end (
  input  wire logic [1:0] lvl_i, // Wanted pin level
  output logic      [1:0] pin_o  // Latch pin per probe
);
  initial pin_o = 2'h0;
  // Pin moves off the clock edge, as a real sensor does
  always @(lvl_i) pin_o <= #3 lvl_i;
endmodule

// [testbench/ptp_probe_ctrl_tb.sv]
`timescale 1ns/1ns
module ptp_probe_ctrl_tb;
  logic        clk_i = 0, reset_n_i = 0, wr_en_i = 0;
  logic [15:0] wr_data_i = 0, ctrl_o;
  logic [1:0]  ext, org = 0, tim = 0, cap, lvl = 0;
  logic [31:0] position_i = 0, p1, p2;
  logic [32:0] q[$];
  int          miscompares = 0, n_checks = 0, seed = 1527;
  always #4 clk_i = ~clk_i;
  ptp_far_end u_ptp_far_end (.lvl_i(lvl), .pin_o(ext));
  ptp_probe_ctrl u_ptp_probe_ctrl (.clk_i, .reset_n_i, .wr_en_i,
    .wr_data_i, .ctrl_o, .external_latch_input_one_i(ext),
    .excitation_origin_output_i(org), .timing_pulse_output_i(tim),
    .position_i, .captured_o(cap), .cap_pos1_o(p1), .cap_pos2_o(p2));
  // ********
  // Tasks
  // ********
  task automatic cmp_word(input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t word got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_cap(input logic [32:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t capture got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    @(negedge clk_i) {wr_en_i, wr_data_i} = {1'b1, d};
    @(negedge clk_i) wr_en_i = 0;
    cmp_word(ctrl_o, d);
  endtask
  // Source 0 pin, 1 origin, 2 timing; position held while latching
  task automatic trig(input int c, s, input logic v, e);
    @(negedge clk_i) position_i = $random(seed);
    if (s == 0) lvl[c] = v;
    else if (s == 1) org[c] = v;
    else tim[c] = v;
    if (e) q.push_back({c[0], position_i});
    repeat (8) @(negedge clk_i);
  endtask
  // Sampled mid-cycle, clear of the edge that launches the pulse
  always @(negedge clk_i) if (cap !== 2'h0) begin
    if (q.size() == 0) cmp_cap({31'h0, cap}, 33'h0);
    else cmp_cap({cap[1], cap[1] ? p2 : p1}, q.pop_front());
  end
  initial begin
    repeat (16) @(negedge clk_i);
    reset_n_i = 1;
    cmp_word(ctrl_o, 16'h0000);
    // Master keeps reserved bits 3, 6 and 7 at zero
    wr(16'($random(seed)) & 16'hFF37);
    wr(16'h0015);
    trig(0, 1, 1, 1);
    trig(0, 1, 0, 0);
    trig(0, 2, 1, 0);
    trig(0, 2, 0, 0);
    wr(16'h0014);
    wr(16'h0015);
    trig(0, 2, 1, 1);
    trig(0, 2, 0, 0);
    wr(16'h0027);
    trig(0, 1, 1, 0);
    trig(0, 1, 0, 1);
    trig(0, 1, 1, 0);
    trig(0, 1, 0, 1);
    // Probe one armed for rising origin edges but disabled
    wr(16'h3314);
    trig(1, 0, 1, 1);
    trig(1, 0, 0, 1);
    trig(0, 1, 1, 0);
    wr(16'h1511);
    trig(0, 0, 1, 1);
    trig(1, 1, 1, 1);
    for (int i = 0; i < 20 && q.size() > 0; i++) @(negedge clk_i);
    if (q.size() > 0) cmp_word(16'(q.size()), 16'h0000);
    stop_test();
  end
endmodule
